// file: hw/bcwd_top.sv
// Module: boot configuration word 0 decoder with Wishbone registers
// What this block does
// - Boundary field bits 18..10 block writes to low program flash pages.
// - Boundary grows 1 KB per step below all ones; 111111011 gives 0x1000.
// - All-zero boundary field protects all protectable flash when large_flash is set; small parts then get a 127 KB boundary.
// - Parts below 256 KB ignore the top two boundary field bits.
// - Channel select 11,10,01,00 routes debug to pairs 1,2,3,4.
// - Word bit 2 sets the reset value of the runtime scan enable.
// - Debugger disabled when upper debug field bit is one.
// - Code protection forces the debug field to 11.
//
// Design decisions made here: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module bcwd_top
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [31:0] config_word,
  input wire logic code_protect,
  input wire logic large_flash,
  input wire logic [31:0] flash_wr_addr,
  input wire logic flash_wr_req,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic flash_wr_block,
  output logic [31:0] protect_boundary,
  output logic [3:0] debug_pair_en,
  output logic scan_port_enable,
  output logic debugger_enable,
  output logic config_valid
);
  // ***************************************************
  // Word capture
  // ***************************************************
  logic [31:0] word_reg;
  logic loaded_reg;
  logic loaded_d_reg;
  logic [31:0] boundary;
  logic protect_all;
  logic [1:0] dbg_field;
  logic [31:0] ctrl_reg;
  logic code_protect_reg;
  bcwd_word_latch u_latch
  (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .word_in(config_word),
    .word_reg(word_reg),
    .loaded_reg(loaded_reg)
  );
  bcwd_bound_calc u_bound
  (
    .field(word_reg[bcwd_pkg::BCWD_PWP_LSB +: bcwd_pkg::BCWD_PWP_W]),
    .large_flash(large_flash),
    .boundary(boundary),
    .protect_all(protect_all)
  );
  // Code protect strap caught with the word, not sampled live
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      code_protect_reg <= 1'b1;
    else if (!loaded_reg)
      code_protect_reg <= code_protect;
  end
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      loaded_d_reg <= 1'b0;
    else
      loaded_d_reg <= loaded_reg;
  end
  // ***************************************************
  // Decoded outputs
  // ***************************************************
  // code protection overrides debug field
  assign dbg_field = code_protect_reg ? 2'h3 : word_reg[1:0];
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      protect_boundary <= 32'h0000_0000;
      debug_pair_en <= 4'h0;
      debugger_enable <= 1'b0;
      config_valid <= 1'b0;
    end
    else if (loaded_reg)
    begin
      protect_boundary <= boundary;
      case (bcwd_pkg::bcwd_pair_t'(word_reg[bcwd_pkg::BCWD_SEL_LSB +: 2]))
        bcwd_pkg::BCWD_PAIR_1: debug_pair_en <= 4'h1;
        bcwd_pkg::BCWD_PAIR_2: debug_pair_en <= 4'h2;
        bcwd_pkg::BCWD_PAIR_3: debug_pair_en <= 4'h4;
        bcwd_pkg::BCWD_PAIR_4: debug_pair_en <= 4'h8;
        default: debug_pair_en <= 4'h1;
      endcase
      debugger_enable <= ~dbg_field[bcwd_pkg::BCWD_DBG_HI_BIT];
      config_valid <= 1'b1;
    end
  end
  // write block held until the decode settles, then blocks requests below the boundary, or all when protect_all
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      flash_wr_block <= 1'b1;
    else if (!loaded_d_reg)
      flash_wr_block <= 1'b1;
    else
      flash_wr_block <= flash_wr_req && (protect_all || (flash_wr_addr < protect_boundary));
  end
  // ***************************************************
  // Runtime control register
  // ***************************************************
  logic wb_hit;
  assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      ctrl_reg <= bcwd_pkg::BCWD_CTRL_RESET;
    else if (loaded_reg && !loaded_d_reg)
      ctrl_reg[bcwd_pkg::BCWD_CTRL_SCAN_BIT] <= word_reg[bcwd_pkg::BCWD_SCAN_BIT];
    else if (wb_hit && wb_we_i && wb_adr_i == bcwd_pkg::BCWD_OFF_CTRL && wb_sel_i[0])
      ctrl_reg[7:0] <= wb_dat_i[7:0];
  end
  // scan port follows its enable bit
  assign scan_port_enable = ctrl_reg[bcwd_pkg::BCWD_CTRL_SCAN_BIT];
  // ***************************************************
  // Wishbone slave
  // ***************************************************
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= wb_hit;
  end
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      wb_dat_o <= 32'h0000_0000;
    else if (wb_hit && !wb_we_i)
    begin
      case (wb_adr_i)
        bcwd_pkg::BCWD_OFF_WORD0: wb_dat_o <= word_reg;
        bcwd_pkg::BCWD_OFF_CTRL: wb_dat_o <= ctrl_reg;
        bcwd_pkg::BCWD_OFF_STATUS: wb_dat_o <= {20'h00000, debug_pair_en, 4'h0,
          code_protect_reg, debugger_enable, protect_all, config_valid};
        bcwd_pkg::BCWD_OFF_BOUND: wb_dat_o <= protect_boundary;
        default: wb_dat_o <= bcwd_pkg::BCWD_UNMAPPED_DATA;
      endcase
    end
  end
endmodule
`default_nettype wire

// file: pkg/bcwd_pkg.sv
// Package: constants for the boot configuration word decoder
package bcwd_pkg;
  // Register map
  localparam logic [31:0] BCWD_OFF_WORD0 = 32'h0000_0000;
  localparam logic [31:0] BCWD_OFF_CTRL = 32'h0000_0004;
  localparam logic [31:0] BCWD_OFF_STATUS = 32'h0000_0008;
  localparam logic [31:0] BCWD_OFF_BOUND = 32'h0000_000C;
  // Word 0 fields
  localparam int BCWD_PWP_LSB = 10;
  localparam int BCWD_PWP_W = 9;
  localparam int BCWD_RSV_LSB = 5;
  localparam int BCWD_RSV_W = 5;
  localparam int BCWD_SEL_LSB = 3;
  localparam int BCWD_SCAN_BIT = 2;
  localparam int BCWD_DBG_HI_BIT = 1;
  // Protection step is 1 KB, expressed as a shift of the step count
  localparam int BCWD_STEP_SHIFT = 10;
  localparam int BCWD_SMALL_PWP_W = 7;
  localparam logic [8:0] BCWD_PWP_OFF = 9'h1FF;
  localparam logic [8:0] BCWD_PWP_SMALL_MASK = 9'h07F;
  // Runtime control reset values
  localparam logic [31:0] BCWD_CTRL_RESET = 32'h0000_0000;
  localparam int BCWD_CTRL_SCAN_BIT = 0;
  localparam logic [31:0] BCWD_UNMAPPED_DATA = 32'h0000_0000;
  typedef enum logic [1:0]
  {
    BCWD_PAIR_4,
    BCWD_PAIR_3,
    BCWD_PAIR_2,
    BCWD_PAIR_1
  } bcwd_pair_t;
endpackage

// file: hw/bcwd_word_latch.sv
// Module: one-shot capture of the configuration word after reset
`timescale 1ns/1ps
`default_nettype none
module bcwd_word_latch
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [31:0] word_in,
  output logic [31:0] word_reg,
  output logic loaded_reg
);
  // Captured once, then frozen until the next reset
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      word_reg <= 32'hFFFF_FFFF;
      loaded_reg <= 1'b0;
    end
    else if (!loaded_reg)
    begin
      word_reg <= word_in;
      loaded_reg <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// file: hw/bcwd_bound_calc.sv
// Module: flash write-protect boundary from the boundary field
`timescale 1ns/1ps
`default_nettype none
module bcwd_bound_calc
(
  input wire logic [8:0] field,
  input wire logic large_flash,
  output logic [31:0] boundary,
  output logic protect_all
);
  logic [8:0] eff;
  logic [8:0] steps;
  always_comb
  begin
    // Small parts lack the top two field bits; they read as ones
    eff = large_flash ? field : (field | ~bcwd_pkg::BCWD_PWP_SMALL_MASK);
    steps = bcwd_pkg::BCWD_PWP_OFF - eff;
    protect_all = (eff == 9'h000);
    boundary = 32'(steps) << bcwd_pkg::BCWD_STEP_SHIFT;
  end
endmodule
`default_nettype wire

// file: test/bcwd_prog_model.sv
// Programmer model that builds configuration word 0
`timescale 1ns/1ps
`default_nettype none
module bcwd_prog_model
(
  input wire logic [8:0] boundary_field,
  input wire logic [1:0] channel_sel,
  input wire logic scan_bit,
  input wire logic [1:0] dbg_field,
  output logic [31:0] word
);
  // reserved bits ones
  // Upper bits left erased, since nothing here decodes them
  assign word = {13'h1FFF, boundary_field, 5'h1F, channel_sel, scan_bit, dbg_field};
endmodule
`default_nettype wire

// file: test/bcwd_top_chk.sv
// Assertion checker for the boot word decoder
`timescale 1ns/1ps
`default_nettype none
module bcwd_top_chk
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [31:0] config_word,
  input wire logic code_protect,
  input wire logic large_flash,
  input wire logic [31:0] flash_wr_addr,
  input wire logic flash_wr_req,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic flash_wr_block,
  input wire logic [31:0] protect_boundary,
  input wire logic [3:0] debug_pair_en,
  input wire logic scan_port_enable,
  input wire logic debugger_enable,
  input wire logic config_valid
);
  logic [8:0] fld;
  // Small parts read the top two field bits as ones
  assign fld = config_word[18:10] | (large_flash ? 9'h000 : 9'h180);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  ack_one_wait_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  valid_delay_a: assert property ($rose(resetn) |-> !config_valid ##2 config_valid)
    else $error("decode late");
  hold_decode_a: assert property (config_valid |=> config_valid && $stable(protect_boundary)
    && $stable(debug_pair_en) && $stable(debugger_enable))
    else $error("decode moved");
  bound_value_a: assert property (config_valid && fld != 9'h000 |->
    protect_boundary == {13'h0000, 9'h1FF - fld, 10'h000}) else $error("bad boundary");
  block_below_a: assert property (config_valid && flash_wr_req &&
    (fld == 9'h000 || flash_wr_addr < protect_boundary) |=> flash_wr_block)
    else $error("write not blocked");
  no_req_free_a: assert property (config_valid && !flash_wr_req |=> !flash_wr_block)
    else $error("block without request");
  pair_map_a: assert property (config_valid |->
    debug_pair_en == 4'h1 << (2'h3 - config_word[4:3])) else $error("bad pair");
  debug_gate_a: assert property (config_valid |->
    debugger_enable == !(config_word[1] || code_protect)) else $error("bad debugger");
  scan_seed_a: assert property ($rose(config_valid) |->
    scan_port_enable == config_word[2]) else $error("bad scan seed");
  cover property (config_valid && flash_wr_block);
  cover property (config_valid && code_protect);
  cover property (wb_ack_o && wb_cyc_i);
endmodule
bind bcwd_top bcwd_top_chk i_bcwd_top_chk (.*);
`default_nettype wire

// file: test/tb.sv
// Testbench for the boot word decoder
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic ref_clk, resetn, code_protect, large_flash, flash_wr_req, wb_cyc_i, wb_stb_i, wb_we_i;
  logic wb_ack_o, flash_wr_block, scan_port_enable, debugger_enable, config_valid, scan;
  logic [31:0] config_word, flash_wr_addr, wb_adr_i, wb_dat_i, wb_dat_o, protect_boundary;
  logic [31:0] q, bnd, word;
  logic [3:0] wb_sel_i, debug_pair_en;
  logic [8:0] fld, f;
  logic [1:0] sel, dbg;
  logic [15:0] cfg [4] = '{16'hFDF1, 16'h0045, 16'h7FB3, 16'h7F8C};
  int mismatches, compares, cycles;
  bcwd_top i_bcwd_top (.*);
  bcwd_prog_model i_bcwd_prog_model (.boundary_field(fld), .channel_sel(sel),
    .scan_bit(scan), .dbg_field(dbg), .word(config_word));
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // Ceiling well above the roughly 130 cycles the tests need
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      mismatches++;
      summarize;
    end
  end
  task summarize;
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task wb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    @(posedge ref_clk);
    while (wb_ack_o !== 1'b1) @(posedge ref_clk);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  initial
  begin
    {resetn, wb_cyc_i, wb_stb_i, wb_we_i, flash_wr_req} = 5'h00;
    {wb_adr_i, wb_dat_i, flash_wr_addr} = '0;
    wb_sel_i = 4'hF;
    {fld, sel, scan, dbg, code_protect, large_flash} = cfg[0];
    for (int i = 0; i < 4; i++)
    begin
      @(posedge ref_clk);
      resetn <= 1'b0;
      {fld, sel, scan, dbg, code_protect, large_flash} <= cfg[i];
      repeat (2) @(posedge ref_clk);
      resetn <= 1'b1;
      repeat (4) @(posedge ref_clk);
      f = large_flash ? fld : fld | 9'h180;
      bnd = {13'h0000, 9'h1FF - f, 10'h000};
      word = {13'h1FFF, fld, 5'h1F, sel, scan, dbg};
      if (f != 9'h000) check(protect_boundary, bnd);
      check(32'(debug_pair_en), 32'h1 << (3 - sel));
      check(32'(scan_port_enable), 32'(scan));
      check(32'(debugger_enable), 32'(!(dbg[1] | code_protect)));
      flash_wr_req <= 1'b1;
      flash_wr_addr <= bnd - 32'h4;
      repeat (2) @(posedge ref_clk);
      check(32'(flash_wr_block), 32'(f == 9'h000 || bnd != 0));
      flash_wr_addr <= bnd;
      repeat (2) @(posedge ref_clk);
      check(32'(flash_wr_block), 32'(f == 9'h000));
      flash_wr_req <= 1'b0;
      repeat (2) @(posedge ref_clk);
      check(32'(flash_wr_block), 32'h0);
      wb(1'b1, bcwd_pkg::BCWD_OFF_CTRL, 32'(!scan));
      @(posedge ref_clk);
      check(32'(scan_port_enable), 32'(!scan));
      wb(1'b1, bcwd_pkg::BCWD_OFF_WORD0, 32'h0);
      wb(1'b0, bcwd_pkg::BCWD_OFF_WORD0, 32'h0);
      check(q, word);
      wb(1'b0, bcwd_pkg::BCWD_OFF_BOUND, 32'h0);
      check(q, bnd);
      wb(1'b0, bcwd_pkg::BCWD_OFF_STATUS, 32'h0);
      check(q, {20'h00000, 4'(4'h1 << (3 - sel)), 4'h0, code_protect,
        !(dbg[1] | code_protect), f == 9'h000, 1'b1});
      wb(1'b0, 32'h10, 32'h0);
      check(q, bcwd_pkg::BCWD_UNMAPPED_DATA);
    end
    summarize;
  end
endmodule
`default_nettype wire
